/* File: design/trig_cmd_pkg.sv */
// constants for the trigger, measurement and setup-save command block
// assumes a 50 MHz system clock and a 32-bit classic Wishbone master
package trig_cmd_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  // sample windows in microseconds
  localparam int WIN50_US = 20000;
  localparam int WIN60_US = 16600;
  localparam int WIN125_US = 10000;
  localparam int WIN50_CYC = WIN50_US * CYC_PER_US;
  localparam int WIN60_CYC = WIN60_US * CYC_PER_US;
  localparam int WIN125_CYC = WIN125_US * CYC_PER_US;
  // accepted measurement rates in hertz
  localparam logic [7:0] RATE_50 = 8'h32;
  localparam logic [7:0] RATE_60 = 8'h3C;
  localparam logic [7:0] RATE_125 = 8'h7D;
  // register byte offsets
  localparam logic [7:0] A_CMD = 8'h00;
  localparam logic [7:0] A_CTRL = 8'h04;
  localparam logic [7:0] A_COND = 8'h08;
  localparam logic [7:0] A_ENAB = 8'h0C;
  localparam logic [7:0] A_EVENT = 8'h10;
  localparam logic [7:0] A_VTRIG = 8'h14;
  localparam logic [7:0] A_ITRIG = 8'h18;
  localparam logic [7:0] A_OUT_V = 8'h1C;
  localparam logic [7:0] A_OUT_I = 8'h20;
  localparam logic [7:0] A_RATE_SEL = 8'h24;
  localparam logic [7:0] A_MEAS_V = 8'h28;
  localparam logic [7:0] A_MEAS_I = 8'h2C;
  localparam logic [7:0] A_LIST_CNT = 8'h30;
  localparam logic [7:0] A_SAMP_CNT = 8'h34;
  localparam logic [7:0] A_SAMP_SEL = 8'h38;
  localparam logic [7:0] A_SAMP_DATA = 8'h3C;
  localparam logic [7:0] A_ERR = 8'h40;
  // command codes, low nibble of the command register
  localparam logic [3:0] CMD_INIT = 4'h1;
  localparam logic [3:0] CMD_ABORT = 4'h2;
  localparam logic [3:0] CMD_BUS_TRG = 4'h3;
  localparam logic [3:0] CMD_RESET = 4'h4;
  localparam logic [3:0] CMD_SAVE_SETUP = 4'h5;
  // setup groups for the save command
  localparam logic [1:0] GRP_INTF = 2'h0;
  localparam logic [1:0] SERIAL_GROUP = 2'h1;
  localparam logic [1:0] LIMITS_GROUP = 2'h2;
  localparam logic [1:0] OUTPUT_GROUP = 2'h3;
  // field positions
  localparam int GRP_LSB = 4;
  localparam int CONT_BIT = 0;
  localparam int SRC_BIT = 1;
  localparam int WTG_BIT = 5;
  localparam int TYPE_BIT = 8;
  // reset values and codes
  localparam logic [15:0] LIST_CNT_ONE = 16'h0001;
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_COMMAND = 16'hFF9C;
endpackage

/* File: design/trig_cmd.sv */
// trigger arming, trigger levels, waiting-for-trigger status, measurement
// sampling and setup-save requests, behind a classic Wishbone slave
// assumes list engine and converters on clk_sys; ext_trig is an async pin
//
// Our own choices: the Wishbone slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
module trig_cmd #(
  parameter int LVL_W = 16,
  parameter int SAMP_N = 8,
  parameter int CNT_W = 20,
  parameter int WIN50_CYC = trig_cmd_pkg::WIN50_CYC,
  parameter int WIN60_CYC = trig_cmd_pkg::WIN60_CYC,
  parameter int WIN125_CYC = trig_cmd_pkg::WIN125_CYC
) (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // trigger pin
  input wire logic ext_trig,
  // converters
  input wire logic [LVL_W-1:0] sense_v,
  input wire logic [LVL_W-1:0] out_cur,
  // list engine
  input wire logic list_run,
  input wire logic list_curr,
  input wire logic samp_stb,
  input wire logic [LVL_W-1:0] samp_val,
  // output levels and status
  output logic [LVL_W-1:0] out_v,
  output logic [LVL_W-1:0] out_i,
  output logic wtg,
  // setup store
  output logic save_stb,
  output logic [1:0] save_group
);
  localparam int CW = $clog2(SAMP_N + 1);
  localparam int SW = $clog2(SAMP_N);

  if (LVL_W < 1 || LVL_W > 16 || SAMP_N < 2 || SAMP_N > 8 ||
      WIN50_CYC < 1 || WIN60_CYC < 1 || WIN125_CYC < 1 ||
      WIN50_CYC > 2**CNT_W || WIN60_CYC > 2**CNT_W ||
      WIN125_CYC > 2**CNT_W)
  begin : g_chk
    $error("trig_cmd: unsupported parameters");
  end

  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] wd, input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (wd & m);
  endfunction

  // bus access
  logic ack_r;
  logic acc;
  logic wr;
  logic rd;
  logic [31:0] dat_r;
  logic [31:0] rd_mux;
  assign acc = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr = acc & wb_we_i;
  assign rd = acc & ~wb_we_i;
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      ack_r <= 1'b0;
    else if (ce)
      ack_r <= acc;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      dat_r <= 32'h00000000;
    else if (ce && rd)
      dat_r <= rd_mux;
  end

  // command decode; only the low byte lane carries a command
  logic cmd_wr;
  logic cmd_init;
  logic cmd_abort;
  logic cmd_bus_trg;
  logic cmd_rst;
  logic cmd_save;
  assign cmd_wr = wr && wb_adr_i == trig_cmd_pkg::A_CMD && wb_sel_i[0];
  assign cmd_init = cmd_wr && wb_dat_i[3:0] == trig_cmd_pkg::CMD_INIT;
  assign cmd_abort = cmd_wr && wb_dat_i[3:0] == trig_cmd_pkg::CMD_ABORT;
  assign cmd_bus_trg = cmd_wr && wb_dat_i[3:0] == trig_cmd_pkg::CMD_BUS_TRG;
  assign cmd_rst = cmd_wr && wb_dat_i[3:0] == trig_cmd_pkg::CMD_RESET;
  assign cmd_save = cmd_wr && wb_dat_i[3:0] == trig_cmd_pkg::CMD_SAVE_SETUP;

  // external trigger pin, synchronised then edge detected
  logic ext_s1_r;
  logic ext_s2_r;
  logic ext_s3_r;
  logic ext_edge;
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
    end
    else if (ce)
    begin
      ext_s1_r <= ext_trig;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end
  assign ext_edge = ext_s2_r & ~ext_s3_r;

  // control: continuous mode and trigger source
  logic cont_r;
  logic src_ext_r;
  logic [31:0] ctrl_m;
  assign ctrl_m = merge({30'h0, src_ext_r, cont_r}, wb_dat_i, wb_sel_i);
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cont_r <= 1'b0;
      src_ext_r <= 1'b0;
    end
    else if (ce)
    begin
      if (cmd_rst)
        cont_r <= 1'b0;
      else if (wr && wb_adr_i == trig_cmd_pkg::A_CTRL)
        cont_r <= ctrl_m[trig_cmd_pkg::CONT_BIT];
      if (wr && wb_adr_i == trig_cmd_pkg::A_CTRL)
        src_ext_r <= ctrl_m[trig_cmd_pkg::SRC_BIT];
    end
  end

  // arming; a bus trigger with the external source selected is dropped
  logic armed_r;
  logic armed_nxt;
  logic trig_acc;
  assign trig_acc = armed_r && ((cmd_bus_trg && !src_ext_r) ||
                    (ext_edge && src_ext_r));
  always_comb
  begin
    armed_nxt = armed_r;
    if (cmd_rst)
      armed_nxt = 1'b0;
    else if (cont_r)
      armed_nxt = 1'b1;
    else if (cmd_init)
      armed_nxt = 1'b1;
    else if (cmd_abort)
      armed_nxt = 1'b0;
    else if (trig_acc)
      armed_nxt = 1'b0;
  end
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      armed_r <= 1'b0;
    else if (ce)
      armed_r <= armed_nxt;
  end

  // waiting-for-trigger status
  logic wtg_r;
  logic wtg_nxt;
  always_comb
  begin
    wtg_nxt = armed_nxt;
    if (cmd_rst)
      wtg_nxt = 1'b0;
    else if (cont_r && !src_ext_r)
      wtg_nxt = 1'b1;
    // single mode already follows armed_nxt, so init can win over an edge
    else if (cont_r && trig_acc)
      wtg_nxt = 1'b0;
  end
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      wtg_r <= 1'b0;
    else if (ce)
      wtg_r <= wtg_nxt;
  end
  assign wtg = wtg_r;

  // operation enable and event; a new event beats the read-clear
  logic [15:0] enab_r;
  logic [15:0] event_r;
  logic [31:0] enab_m;
  logic ev_set;
  assign enab_m = merge({16'h0, enab_r}, wb_dat_i, wb_sel_i);
  assign ev_set = enab_r[trig_cmd_pkg::WTG_BIT] && (wtg_nxt != wtg_r);
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      enab_r <= 16'h0000;
    else if (ce && wr && wb_adr_i == trig_cmd_pkg::A_ENAB)
      enab_r <= enab_m[15:0];
  end
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      event_r <= 16'h0000;
    else if (ce)
    begin
      if (rd && wb_adr_i == trig_cmd_pkg::A_EVENT)
        event_r <= 16'h0000;
      if (ev_set)
        event_r[trig_cmd_pkg::WTG_BIT] <= 1'b1;
    end
  end

  // trigger levels and applied output levels
  logic [LVL_W-1:0] vtrig_r;
  logic [LVL_W-1:0] itrig_r;
  logic [LVL_W-1:0] out_v_r;
  logic [LVL_W-1:0] out_i_r;
  logic [31:0] vtrig_m;
  logic [31:0] itrig_m;
  logic [31:0] outv_m;
  logic [31:0] outi_m;
  assign vtrig_m = merge(32'(vtrig_r), wb_dat_i, wb_sel_i);
  assign itrig_m = merge(32'(itrig_r), wb_dat_i, wb_sel_i);
  assign outv_m = merge(32'(out_v_r), wb_dat_i, wb_sel_i);
  assign outi_m = merge(32'(out_i_r), wb_dat_i, wb_sel_i);
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      vtrig_r <= '0;
      itrig_r <= '0;
    end
    else if (ce && wr)
    begin
      if (wb_adr_i == trig_cmd_pkg::A_VTRIG)
        vtrig_r <= vtrig_m[LVL_W-1:0];
      if (wb_adr_i == trig_cmd_pkg::A_ITRIG)
        itrig_r <= itrig_m[LVL_W-1:0];
    end
  end
  // a trigger in the same cycle as a direct write wins
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      out_v_r <= '0;
      out_i_r <= '0;
    end
    else if (ce)
    begin
      if (trig_acc)
      begin
        out_v_r <= vtrig_r;
        out_i_r <= itrig_r;
      end
      else if (wr && wb_adr_i == trig_cmd_pkg::A_OUT_V)
        out_v_r <= outv_m[LVL_W-1:0];
      else if (wr && wb_adr_i == trig_cmd_pkg::A_OUT_I)
        out_i_r <= outi_m[LVL_W-1:0];
    end
  end
  assign out_v = out_v_r;
  assign out_i = out_i_r;

  // measurement rate and window; a new rate applies at the next reload
  logic [7:0] rate_r;
  logic [CNT_W-1:0] win_cnt_r;
  logic [CNT_W-1:0] win_len;
  logic [LVL_W-1:0] meas_v_r;
  logic [LVL_W-1:0] meas_i_r;
  logic rate_ok;
  assign rate_ok = wb_dat_i[7:0] == trig_cmd_pkg::RATE_50 ||
                   wb_dat_i[7:0] == trig_cmd_pkg::RATE_60 ||
                   wb_dat_i[7:0] == trig_cmd_pkg::RATE_125;
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      rate_r <= trig_cmd_pkg::RATE_60;
    else if (ce && wr && wb_adr_i == trig_cmd_pkg::A_RATE_SEL &&
             wb_sel_i[0] && rate_ok)
      rate_r <= wb_dat_i[7:0];
  end
  always_comb
  begin
    case (rate_r)
      trig_cmd_pkg::RATE_50: win_len = CNT_W'(WIN50_CYC - 1);
      trig_cmd_pkg::RATE_125: win_len = CNT_W'(WIN125_CYC - 1);
      default: win_len = CNT_W'(WIN60_CYC - 1);
    endcase
  end
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      win_cnt_r <= '0;
      meas_v_r <= '0;
      meas_i_r <= '0;
    end
    else if (ce)
    begin
      if (win_cnt_r == '0)
      begin
        win_cnt_r <= win_len;
        meas_v_r <= sense_v;
        meas_i_r <= out_cur;
      end
      else
        win_cnt_r <= win_cnt_r - 1'b1;
    end
  end

  // captured samples of the running list, held in flip-flops
  logic [LVL_W-1:0] samp_mem [SAMP_N];
  logic [CW-1:0] scount_r;
  logic stype_r;
  logic run_d_r;
  logic [15:0] lcount_r;
  logic [SW-1:0] ssel_r;
  logic [31:0] lcnt_m;
  assign lcnt_m = merge({16'h0, lcount_r}, wb_dat_i, wb_sel_i);
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      run_d_r <= 1'b0;
    else if (ce)
      run_d_r <= list_run;
  end
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      scount_r <= '0;
      stype_r <= 1'b0;
      for (int k = 0; k < SAMP_N; k++)
        samp_mem[k] <= '0;
    end
    else if (ce)
    begin
      if (list_run && !run_d_r)
      begin
        scount_r <= '0;
        stype_r <= list_curr;
      end
      else if (list_run && samp_stb && scount_r < CW'(SAMP_N))
      begin
        samp_mem[scount_r[SW-1:0]] <= samp_val;
        scount_r <= scount_r + 1'b1;
      end
    end
  end
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      lcount_r <= trig_cmd_pkg::LIST_CNT_ONE;
      ssel_r <= '0;
    end
    else if (ce && wr)
    begin
      if (wb_adr_i == trig_cmd_pkg::A_LIST_CNT)
        lcount_r <= lcnt_m[15:0];
      if (wb_adr_i == trig_cmd_pkg::A_SAMP_SEL && wb_sel_i[0])
        ssel_r <= wb_dat_i[SW-1:0];
    end
  end

  // error code; a fresh error beats the read-clear
  logic [15:0] err_r;
  logic samp_rd;
  logic samp_bad;
  assign samp_rd = rd && wb_adr_i == trig_cmd_pkg::A_SAMP_DATA;
  assign samp_bad = samp_rd && lcount_r != trig_cmd_pkg::LIST_CNT_ONE;
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      err_r <= trig_cmd_pkg::ERR_NONE;
    else if (ce)
    begin
      if (samp_bad)
        err_r <= trig_cmd_pkg::ERR_COMMAND;
      else if (rd && wb_adr_i == trig_cmd_pkg::A_ERR)
        err_r <= trig_cmd_pkg::ERR_NONE;
    end
  end

  // setup save request to the nonvolatile store
  logic save_stb_r;
  logic [1:0] save_group_r;
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      save_stb_r <= 1'b0;
      save_group_r <= trig_cmd_pkg::GRP_INTF;
    end
    else if (ce)
    begin
      save_stb_r <= cmd_save;
      if (cmd_save)
        save_group_r <= wb_dat_i[trig_cmd_pkg::GRP_LSB +: 2];
    end
  end
  // the store picks the group's variables from the group code:
  // interface = bus address and system setup
  // serial = state, baud, pacing, echo
  // limits = limits and maximum protection values
  // output = on/off state and operating mode
  assign save_stb = save_stb_r;
  assign save_group = save_group_r;

  // read mux; unmapped addresses read zero
  always_comb
  begin
    rd_mux = 32'h00000000;
    case (wb_adr_i)
      trig_cmd_pkg::A_CTRL: rd_mux = {30'h0, src_ext_r, cont_r};
      trig_cmd_pkg::A_COND: rd_mux[trig_cmd_pkg::WTG_BIT] = wtg_r;
      trig_cmd_pkg::A_ENAB: rd_mux = {16'h0, enab_r};
      trig_cmd_pkg::A_EVENT: rd_mux = {16'h0, event_r};
      trig_cmd_pkg::A_VTRIG: rd_mux = 32'(vtrig_r);
      trig_cmd_pkg::A_ITRIG: rd_mux = 32'(itrig_r);
      trig_cmd_pkg::A_OUT_V: rd_mux = 32'(out_v_r);
      trig_cmd_pkg::A_OUT_I: rd_mux = 32'(out_i_r);
      trig_cmd_pkg::A_RATE_SEL: rd_mux = {24'h0, rate_r};
      trig_cmd_pkg::A_MEAS_V: rd_mux = 32'(meas_v_r);
      trig_cmd_pkg::A_MEAS_I: rd_mux = 32'(meas_i_r);
      trig_cmd_pkg::A_LIST_CNT: rd_mux = {16'h0, lcount_r};
      trig_cmd_pkg::A_SAMP_CNT:
      begin
        rd_mux = 32'(scount_r);
        rd_mux[trig_cmd_pkg::TYPE_BIT] = stype_r;
      end
      trig_cmd_pkg::A_SAMP_SEL: rd_mux = 32'(ssel_r);
      trig_cmd_pkg::A_SAMP_DATA:
        if (!samp_bad && CW'(ssel_r) < scount_r)
          rd_mux = 32'(samp_mem[ssel_r]);
      trig_cmd_pkg::A_ERR: rd_mux = {16'h0, err_r};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  AST_INIT_ARMS: assert property (
    ce && cmd_init && !cont_r |=> armed_r && wtg_r)
    else $error("initiate did not arm");
  AST_TRIG_LEVELS: assert property (
    ce && trig_acc |=> out_v == $past(vtrig_r) && out_i == $past(itrig_r))
    else $error("trigger levels not applied");
  AST_ONE_SHOT: assert property (
    ce && trig_acc && !cont_r && !cmd_init |=> !armed_r)
    else $error("single trigger left system armed");
  AST_CONT_ARMED: assert property (
    ce && cont_r && !cmd_rst |=> armed_r)
    else $error("continuous mode not armed");
  AST_WTG_BUS: assert property (
    ce && cont_r && !src_ext_r && !cmd_rst |=> wtg_r)
    else $error("waiting bit low in continuous bus mode");
  AST_WTG_EXT: assert property (
    ce && cont_r && src_ext_r && trig_acc && !cmd_rst
    ##1 ce && cont_r && !cmd_rst |-> !wtg_r ##1 wtg_r)
    else $error("waiting bit did not pulse low on external trigger");
  AST_EVENT: assert property (
    ce && enab_r[trig_cmd_pkg::WTG_BIT] && wtg_nxt != wtg_r |=>
    event_r[trig_cmd_pkg::WTG_BIT])
    else $error("waiting transition not latched");
  AST_RESET_CMD: assert property (
    ce && cmd_rst |=> !cont_r && !wtg_r && !armed_r)
    else $error("reset command incomplete");
  AST_ABORT: assert property (
    ce && cmd_abort && !cont_r |=> !armed_r)
    else $error("abort did not disarm");
  AST_SAMPLE_ERR: assert property (
    ce && samp_bad |=> err_r == trig_cmd_pkg::ERR_COMMAND && dat_r == 32'h0)
    else $error("sample readout with bad loop count");
endmodule
`default_nettype wire

/* File: dv/analog_side_model.sv */
// far-side model: converters, list engine and trigger pin
// assumes the bench pulses go_list and go_ext for one clk_sys cycle
`timescale 1ns/100ps
`default_nettype none
module analog_side_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // bench requests
  input wire logic go_list,
  input wire logic go_curr,
  input wire logic go_ext,
  input wire logic [15:0] lvl_v,
  input wire logic [15:0] lvl_i,
  // toward the block
  output logic [15:0] sense_v,
  output logic [15:0] out_cur,
  output logic list_run,
  output logic list_curr,
  output logic samp_stb,
  output logic [15:0] samp_val,
  output logic ext_trig
);
  logic [4:0] step_r;
  logic [2:0] pin_r;
  // converters lag the analog levels by one cycle
  always_ff @(posedge clk_sys)
  begin
    sense_v <= lvl_v;
    out_cur <= lvl_i;
  end
  // eight strobes, one every other cycle
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      step_r <= 5'h00;
      list_run <= 1'b0;
      list_curr <= 1'b0;
    end
    else if (go_list)
    begin
      step_r <= 5'h10;
      list_run <= 1'b1;
      list_curr <= go_curr;
    end
    else if (step_r != 5'h00)
      step_r <= step_r - 5'h01;
    else
      list_run <= 1'b0;
  end
  assign samp_stb = list_run && step_r[0];
  // value scrambled between strobes so a late latch is caught
  assign samp_val = samp_stb ? {13'h1400, ~step_r[3:1]} : ~{13'h1400, step_r[2:0]};
  // pin idles low, pulse four cycles wide
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      pin_r <= 3'h0;
    else if (go_ext)
      pin_r <= 3'h4;
    else if (pin_r != 3'h0)
      pin_r <= pin_r - 3'h1;
  end
  assign ext_trig = (pin_r != 3'h0);
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// self-checking bench for the trigger and measurement command block
// assumes short sample windows; bench acts as wishbone master
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin \
  check_count++; \
  if ((got) !== (exp)) \
  begin \
    bad_count++; \
    $display("MISMATCH %s exp=%h got=%h", nm, exp, got); \
  end \
end
module tb;
  logic clk_sys, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic ext_trig, list_run, list_curr, samp_stb, wtg, save_stb;
  logic [15:0] sense_v, out_cur, samp_val, out_v, out_i, lvl_v, lvl_i;
  logic [1:0] save_group, seen_grp;
  logic go_list, go_curr, go_ext, ce;
  int bad_count, check_count, save_seen;

  trig_cmd #(.WIN50_CYC(50), .WIN60_CYC(40), .WIN125_CYC(20)) dut (
    .clk_sys, .rst, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ext_trig, .sense_v,
    .out_cur, .list_run, .list_curr, .samp_stb, .samp_val, .out_v, .out_i,
    .wtg, .save_stb, .save_group);

  analog_side_model far (.clk_sys, .rst, .go_list, .go_curr, .go_ext,
    .lvl_v, .lvl_i, .sense_v, .out_cur, .list_run, .list_curr, .samp_stb,
    .samp_val, .ext_trig);

  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // pulse sampled before the edge's updates land
  always @(posedge clk_sys)
  begin
    if (save_stb === 1'b1)
    begin
      save_seen++;
      seen_grp = save_group;
    end
  end

  task automatic summarize;
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // classic cycle: hold until ack is sampled high, take data and release there
  // no local limit: only the watchdog ends a wait
  task automatic wbx(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do
      @(posedge clk_sys);
    while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    #1;
    `CHK("ack drop", 1'b0, wb_ack_o)
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wbx(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    wbx(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask

  task automatic cmd(input logic [3:0] c, input logic [1:0] g = 2'h0);
    wr(trig_cmd_pkg::A_CMD, {26'h0, g, c});
  endtask

  // one-cycle request to the far side: pin pulse or list run
  task automatic pulse(input logic ext);
    @(posedge clk_sys);
    if (ext)
      go_ext <= 1'b1;
    else
      go_list <= 1'b1;
    @(posedge clk_sys);
    go_ext <= 1'b0;
    go_list <= 1'b0;
    #1;
  endtask

  task automatic t_single;
    wr(trig_cmd_pkg::A_CTRL, 32'h0);
    wr(trig_cmd_pkg::A_VTRIG, 32'h1111);
    wr(trig_cmd_pkg::A_ITRIG, 32'h2222);
    cmd(trig_cmd_pkg::CMD_BUS_TRG);
    `CHK("unarmed trig", 16'h0000, out_v)
    cmd(trig_cmd_pkg::CMD_INIT);
    rdc(trig_cmd_pkg::A_COND, 32'h20, "armed wtg");
    cmd(trig_cmd_pkg::CMD_BUS_TRG);
    `CHK("trig v", 16'h1111, out_v)
    `CHK("trig i", 16'h2222, out_i)
    wr(trig_cmd_pkg::A_VTRIG, 32'h3333);
    cmd(trig_cmd_pkg::CMD_BUS_TRG);
    `CHK("second trig", 16'h1111, out_v)
    cmd(trig_cmd_pkg::CMD_INIT);
    cmd(trig_cmd_pkg::CMD_ABORT);
    cmd(trig_cmd_pkg::CMD_BUS_TRG);
    `CHK("aborted trig", 16'h1111, out_v)
    `CHK("aborted wtg", 1'b0, wtg)
    wr(trig_cmd_pkg::A_OUT_V, 32'h0777);
    `CHK("direct v", 16'h0777, out_v)
    rdc(trig_cmd_pkg::A_OUT_I, 32'h2222, "held i");
    $display("test single end");
  endtask

  task automatic t_cont;
    wr(trig_cmd_pkg::A_CTRL, 32'h1);
    rdc(trig_cmd_pkg::A_CTRL, 32'h1, "cont on");
    `CHK("cont wtg", 1'b1, wtg)
    wr(trig_cmd_pkg::A_VTRIG, 32'h4444);
    cmd(trig_cmd_pkg::CMD_BUS_TRG);
    `CHK("cont trig1", 16'h4444, out_v)
    cmd(trig_cmd_pkg::CMD_ABORT);
    cmd(trig_cmd_pkg::CMD_INIT);
    wr(trig_cmd_pkg::A_VTRIG, 32'h5555);
    cmd(trig_cmd_pkg::CMD_BUS_TRG);
    `CHK("cont trig2", 16'h5555, out_v)
    rdc(trig_cmd_pkg::A_COND, 32'h20, "cont cond");
    cmd(trig_cmd_pkg::CMD_RESET);
    rdc(trig_cmd_pkg::A_CTRL, 32'h0, "reset cont");
    rdc(trig_cmd_pkg::A_COND, 32'h0, "reset wtg");
    $display("test cont end");
  endtask

  task automatic t_ext;
    int n;
    wr(trig_cmd_pkg::A_ENAB, 32'h20);
    wr(trig_cmd_pkg::A_CTRL, 32'h3);
    rdc(trig_cmd_pkg::A_EVENT, 32'h20, "rise event");
    rdc(trig_cmd_pkg::A_EVENT, 32'h0, "event clr");
    wr(trig_cmd_pkg::A_VTRIG, 32'h6666);
    pulse(1'b1);
    for (n = 0; n < 20 && wtg !== 1'b0; n++)
      @(posedge clk_sys) #1;
    `CHK("ext drop", 1'b0, wtg)
    @(posedge clk_sys) #1;
    `CHK("ext back", 1'b1, wtg)
    `CHK("ext lvl", 16'h6666, out_v)
    rdc(trig_cmd_pkg::A_EVENT, 32'h20, "ext event");
    // a pin pulse while the clock enable is low must leave no trace
    wr(trig_cmd_pkg::A_VTRIG, 32'h7777);
    @(posedge clk_sys);
    ce <= 1'b0;
    pulse(1'b1);
    repeat (8) @(posedge clk_sys);
    ce <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK("ce frozen v", 16'h6666, out_v)
    `CHK("ce frozen wtg", 1'b1, wtg)
    $display("test ext end");
  endtask

  task automatic t_meas;
    logic [7:0] rt [3];
    rt = '{trig_cmd_pkg::RATE_50, trig_cmd_pkg::RATE_60, trig_cmd_pkg::RATE_125};
    wr(trig_cmd_pkg::A_RATE_SEL, 32'h40);
    rdc(trig_cmd_pkg::A_RATE_SEL, 32'h3C, "bad rate");
    for (int i = 0; i < 3; i++)
    begin
      wr(trig_cmd_pkg::A_RATE_SEL, {24'h0, rt[i]});
      rdc(trig_cmd_pkg::A_RATE_SEL, {24'h0, rt[i]}, "rate");
    end
    lvl_v <= 16'h0ABC;
    lvl_i <= 16'h0DEF;
    repeat (50) @(posedge clk_sys);
    rdc(trig_cmd_pkg::A_MEAS_V, 32'h0ABC, "meas v");
    rdc(trig_cmd_pkg::A_MEAS_I, 32'h0DEF, "meas i");
    // one short window plus converter lag must refresh the reading
    lvl_v <= 16'h0123;
    repeat (23) @(posedge clk_sys);
    rdc(trig_cmd_pkg::A_MEAS_V, 32'h0123, "window");
    $display("test meas end");
  endtask

  task automatic t_samp;
    for (int t = 0; t < 2; t++)
    begin
      go_curr <= t[0];
      pulse(1'b0);
      for (int n = 0; n < 40 && list_run !== 1'b0; n++)
        @(posedge clk_sys) #1;
      rdc(trig_cmd_pkg::A_SAMP_CNT, {23'h0, t[0], 8'h08}, "samp cnt");
    end
    for (int k = 0; k < 8; k++)
    begin
      wr(trig_cmd_pkg::A_SAMP_SEL, {29'h0, k[2:0]});
      rdc(trig_cmd_pkg::A_SAMP_DATA, {16'h0, 13'h1400, k[2:0]}, "samp");
    end
    wr(trig_cmd_pkg::A_LIST_CNT, 32'h2);
    rdc(trig_cmd_pkg::A_SAMP_DATA, 32'h0, "loop data");
    rdc(trig_cmd_pkg::A_ERR, 32'h0000FF9C, "err code");
    rdc(trig_cmd_pkg::A_ERR, 32'h0, "err clr");
    wr(trig_cmd_pkg::A_LIST_CNT, 32'h1);
    rdc(8'h80, 32'h0, "unmapped");
    $display("test samp end");
  endtask

  task automatic t_save;
    for (int g = 0; g < 4; g++)
    begin
      save_seen = 0;
      cmd(trig_cmd_pkg::CMD_SAVE_SETUP, g[1:0]);
      @(posedge clk_sys) #1;
      `CHK("save pulses", 1, save_seen)
      `CHK("save group", g[1:0], seen_grp)
    end
    $display("test save end");
  endtask

  initial
  begin
    rst = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, go_list, go_curr, go_ext} = 6'h00;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    ce = 1'b1;
    lvl_v = 16'h0000;
    lvl_i = 16'h0000;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    t_single;
    t_cont;
    t_ext;
    t_meas;
    t_samp;
    t_save;
    summarize();
  end

  // about four hundred cycles expected
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    bad_count++;
    $display("MISMATCH watchdog exp=finish got=hang");
    summarize();
  end
endmodule
`default_nettype wire
